// *** src/ssr_defines.svh ***
// Contract
// R1: General status bits 15:12 report the clock ratio monitor count; 1000 means clock present.
// R2: Last reset cause field latched on entry to the off state, codes 000 to 101.
// R3: General status bits 4:0 show the current top-level state code.
// R4: ADC flag register resets to zero; writing one sets a flag, zero leaves it.
// R5: All ADC flags are ORed into one ADC error summary.
// R6: ADC stop-bit error flag on bit 7 when a command lacks its stop bit.
// R7: ADC timeline error flag on bit 6 when a command overlaps the previous one.
// R8: Command error flag on bit 5 when a serial command error is detected.
// R9: Parity error flag on bit 4 on parity mismatch in the serial stream.
// R10: Channel two underflow on bit 3, channel one underflow on bit 1.
// R11: Channel two saturation on bit 2, channel one saturation on bit 0.
// R12: Rail fault register is read-only, resets to zero, one means active fault.
// R13: Mirror bias, reset and offset undervoltage on fault bits 15, 14 and 13.
// R14: Fault bit 12 is main input or analog supply undervoltage.
// R15: Fault bit 10 is undervoltage on any of the 1.1, 1.8, 3.3 or 6 V supplies.
// R16: Converter 3 V regulator undervoltage on bit 9, overvoltage on bit 8.
// R17: Amplifier 3 V uv/ov on 7/6, 5 V ov on 5, photodiode bias uv/ov on 4/3.
// R18: 3.3 V, 1.8 V and 1.1 V undervoltage on fault bits 2, 1 and 0.
// R19: Power-good summary is set whenever any rail fault bit is set.
// R20: ADC error summary sits on main status bit 11.
// R21: Reserved bits read zero and ignore writes.
// R22: Flags update on the system clock; foreign status inputs are synchronised first.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// Register port geometry and offsets.
`define SSR_ADDR_W 8
`define SSR_DATA_W 16
`define SSR_ADDR_GEN_STATUS 8'h05
`define SSR_ADDR_ADC_FLAGS 8'h0D
`define SSR_ADDR_RAIL_FAULT 8'h38
`define SSR_REG_RESET 16'h0000

// General status field layout.
`define SSR_GS_RATIO_MSB 15
`define SSR_GS_RATIO_LSB 12
`define SSR_GS_RSVD_MSB 11
`define SSR_GS_RSVD_LSB 8
`define SSR_GS_CAUSE_MSB 7
`define SSR_GS_CAUSE_LSB 5
`define SSR_GS_STATE_MSB 4
`define SSR_GS_STATE_LSB 0
`define SSR_RATIO_W 4
`define SSR_CAUSE_W 3
`define SSR_STATE_W 5
`define SSR_RSVD4 4'h0
`define SSR_RATIO_MID 4'h8
`define SSR_RATIO_TOL 4'h1

// Reset cause codes.
`define SSR_CAUSE_POWER_ON 3'h0
`define SSR_CAUSE_PROJECTOR_ON_INPUT_LOW 3'h1
`define SSR_CAUSE_WATCHDOG1 3'h2
`define SSR_CAUSE_WATCHDOG2 3'h3
`define SSR_CAUSE_OVER_TEMP 3'h4
`define SSR_CAUSE_SW_CYCLE 3'h5

// ADC flag register layout.
`define SSR_ADC_W 8
`define SSR_ADC_MSB 7
`define SSR_ADC_STOP_BIT 7
`define SSR_ADC_TIMELINE 6
`define SSR_ADC_COMMAND 5
`define SSR_ADC_PARITY 4
`define SSR_ADC_CH2_UNDER 3
`define SSR_ADC_CH2_SAT 2
`define SSR_ADC_CH1_UNDER 1
`define SSR_ADC_CH1_SAT 0
`define SSR_ADC_UPPER_ZERO 8'h00

// Rail fault register layout.
`define SSR_FLT_MIRROR_BIAS 15
`define SSR_FLT_MIRROR_RESET 14
`define SSR_FLT_MIRROR_OFFSET 13
`define SSR_FLT_PG1 12
`define SSR_FLT_RSVD 11
`define SSR_FLT_PG2 10
`define SSR_FLT_CONV_UV 9
`define SSR_FLT_CONV_OV 8
`define SSR_FLT_AMP3_UV 7
`define SSR_FLT_AMP3_OV 6
`define SSR_FLT_AMP5_OV 5
`define SSR_FLT_NEG_UV 4
`define SSR_FLT_NEG_OV 3
`define SSR_FLT_V3P3 2
`define SSR_FLT_V1P8 1
`define SSR_FLT_V1P1 0

// Raw rail monitor vector, one bit per comparator, synchronised as a word.
`define SSR_RAW_W 16
`define SSR_RAW_MIRROR_BIAS 15
`define SSR_RAW_MIRROR_RESET 14
`define SSR_RAW_MIRROR_OFFSET 13
`define SSR_RAW_MAIN_INPUT 12
`define SSR_RAW_ANALOG 11
`define SSR_RAW_V6 10
`define SSR_RAW_CONV_UV 9
`define SSR_RAW_CONV_OV 8
`define SSR_RAW_AMP3_UV 7
`define SSR_RAW_AMP3_OV 6
`define SSR_RAW_AMP5_OV 5
`define SSR_RAW_NEG_UV 4
`define SSR_RAW_NEG_OV 3
`define SSR_RAW_V3P3 2
`define SSR_RAW_V1P8 1
`define SSR_RAW_V1P1 0

`endif

// *** src/ssr_pkg.sv ***
`include "ssr_defines.svh"

package ssr_pkg;

   // Top-level power state codes as reported in the general status register.
   typedef enum logic [4:0] {
      SSR_ST_SHUTDOWN = 5'h00,
      SSR_ST_INIT_A = 5'h01,
      SSR_ST_OFF = 5'h02,
      SSR_ST_INIT_B = 5'h03,
      SSR_ST_INIT_1P1 = 5'h04,
      SSR_ST_INIT_1P8 = 5'h05,
      SSR_ST_INIT_3P3 = 5'h06,
      SSR_ST_RESET_RELEASE = 5'h07,
      SSR_ST_STANDBY = 5'h08,
      SSR_ST_OFFSET_EN = 5'h09,
      SSR_ST_BIAS_EN = 5'h0A,
      SSR_ST_DISPLAY_READY = 5'h0C,
      SSR_ST_DISPLAY_ON = 5'h0D,
      SSR_ST_PARK_INIT = 5'h0E,
      SSR_ST_BIAS_RESET_OFF = 5'h0F,
      SSR_ST_OFFSET_OFF = 5'h10,
      SSR_ST_DISCHARGE = 5'h11
   } ssr_top_state_e;

   // Whole state of the register bank.
   typedef struct packed {
      logic [`SSR_RATIO_W-1:0] ratio;
      logic [`SSR_STATE_W-1:0] topState;
      logic [`SSR_CAUSE_W-1:0] pendCause;
      logic [`SSR_CAUSE_W-1:0] lastReset;
      logic [`SSR_ADC_W-1:0] adcFlags;
      logic [`SSR_DATA_W-1:0] railFault;
      logic [`SSR_DATA_W-1:0] rdData;
      logic rdValid;
   } ssr_bank_s;

   // Whole state of the two-stage synchroniser.
   typedef struct packed {
      logic [`SSR_RAW_W-1:0] meta;
      logic [`SSR_RAW_W-1:0] stable;
   } ssr_sync_s;

endpackage : ssr_pkg

// *** src/ssr_sync.sv ***
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_sync (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [`SSR_RAW_W-1:0] asyncIn,
   output logic [`SSR_RAW_W-1:0] syncOut
);

   ssr_pkg::ssr_sync_s st;
   ssr_pkg::ssr_sync_s next_st;

   // The first stage feeds only the second; each bit crosses on its own, so bits of one
   // rail event may land a cycle apart, which is harmless for independent fault levels.
   always_comb begin
      next_st = st;
      if (clkEn) begin
         next_st.meta = asyncIn; // [R22]
         next_st.stable = st.meta;
      end
   end

   // State register with asynchronous clear.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign syncOut = st.stable;

endmodule : ssr_sync

// *** src/ssr_bank.sv ***
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_bank (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [`SSR_ADDR_W-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic [`SSR_DATA_W-1:0] regWrData,
   input wire logic regRdEn,
   output logic [`SSR_DATA_W-1:0] regRdData,
   output logic regRdValid,
   input wire logic [`SSR_RATIO_W-1:0] clockRatioCount,
   input wire logic [`SSR_STATE_W-1:0] topStateIn,
   input wire logic projOnLowEvent,
   input wire logic watchdog1Event,
   input wire logic watchdog2Event,
   input wire logic overTempEvent,
   input wire logic swPowerCycleEvent,
   input wire logic adcStopBitErr,
   input wire logic adcTimelineErr,
   input wire logic adcCommandErr,
   input wire logic adcParityErr,
   input wire logic adcCh2Underflow,
   input wire logic adcCh2Saturated,
   input wire logic adcCh1Underflow,
   input wire logic adcCh1Saturated,
   input wire logic mirrorBiasRailUv,
   input wire logic mirrorResetRailUv,
   input wire logic mirrorOffsetRailUv,
   input wire logic mainInputRailUv,
   input wire logic analogSupplyRailUv,
   input wire logic supply6vUv,
   input wire logic conv3vUv,
   input wire logic conv3vOv,
   input wire logic amp3vUv,
   input wire logic amp3vOv,
   input wire logic amp5vOv,
   input wire logic negPdBiasUv,
   input wire logic negPdBiasOv,
   input wire logic supply3p3Uv,
   input wire logic supply1p8Uv,
   input wire logic supply1p1Uv,
   output logic pgFaultSummary,
   output logic adcErrorSummary,
   output logic extClockPresent
);

   ssr_pkg::ssr_bank_s st;
   ssr_pkg::ssr_bank_s next_st;
   logic [`SSR_RAW_W-1:0] rawRails;
   logic [`SSR_RAW_W-1:0] syncRails;
   logic [`SSR_ADC_W-1:0] adcEvents;
   logic [`SSR_CAUSE_W-1:0] causeEvent;
   logic causeSeen;
   logic offEntry;
   logic [`SSR_DATA_W-1:0] genStatus;
   logic [`SSR_DATA_W-1:0] faultWord;

   // Address match, shared by the read and write decoders.
   function automatic logic ssr_hit(input logic [`SSR_ADDR_W-1:0] addr, input logic [`SSR_ADDR_W-1:0] off);
      ssr_hit = (addr == off);
   endfunction : ssr_hit

   // Monitor comparators live in the analog domain and glitch freely, so every one
   // of them is synchronised before any OR combines them.
   always_comb begin
      rawRails = '0;
      rawRails[`SSR_RAW_MIRROR_BIAS] = mirrorBiasRailUv;
      rawRails[`SSR_RAW_MIRROR_RESET] = mirrorResetRailUv;
      rawRails[`SSR_RAW_MIRROR_OFFSET] = mirrorOffsetRailUv;
      rawRails[`SSR_RAW_MAIN_INPUT] = mainInputRailUv;
      rawRails[`SSR_RAW_ANALOG] = analogSupplyRailUv;
      rawRails[`SSR_RAW_V6] = supply6vUv;
      rawRails[`SSR_RAW_CONV_UV] = conv3vUv;
      rawRails[`SSR_RAW_CONV_OV] = conv3vOv;
      rawRails[`SSR_RAW_AMP3_UV] = amp3vUv;
      rawRails[`SSR_RAW_AMP3_OV] = amp3vOv;
      rawRails[`SSR_RAW_AMP5_OV] = amp5vOv;
      rawRails[`SSR_RAW_NEG_UV] = negPdBiasUv;
      rawRails[`SSR_RAW_NEG_OV] = negPdBiasOv;
      rawRails[`SSR_RAW_V3P3] = supply3p3Uv;
      rawRails[`SSR_RAW_V1P8] = supply1p8Uv;
      rawRails[`SSR_RAW_V1P1] = supply1p1Uv;
   end

   ssr_sync u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .asyncIn(rawRails),
      .syncOut(syncRails)
   );

   // Map synchronised comparators onto the fault word; bit 11 stays reserved.
   always_comb begin
      faultWord = `SSR_REG_RESET;
      faultWord[`SSR_FLT_MIRROR_BIAS] = syncRails[`SSR_RAW_MIRROR_BIAS]; // [R13]
      faultWord[`SSR_FLT_MIRROR_RESET] = syncRails[`SSR_RAW_MIRROR_RESET]; // [R13]
      faultWord[`SSR_FLT_MIRROR_OFFSET] = syncRails[`SSR_RAW_MIRROR_OFFSET]; // [R13]
      faultWord[`SSR_FLT_PG1] = syncRails[`SSR_RAW_MAIN_INPUT] | syncRails[`SSR_RAW_ANALOG]; // [R14]
      faultWord[`SSR_FLT_PG2] = syncRails[`SSR_RAW_V1P1] | syncRails[`SSR_RAW_V1P8]
         | syncRails[`SSR_RAW_V3P3] | syncRails[`SSR_RAW_V6]; // [R15]
      faultWord[`SSR_FLT_CONV_UV] = syncRails[`SSR_RAW_CONV_UV]; // [R16]
      faultWord[`SSR_FLT_CONV_OV] = syncRails[`SSR_RAW_CONV_OV]; // [R16]
      faultWord[`SSR_FLT_AMP3_UV] = syncRails[`SSR_RAW_AMP3_UV]; // [R17]
      faultWord[`SSR_FLT_AMP3_OV] = syncRails[`SSR_RAW_AMP3_OV]; // [R17]
      faultWord[`SSR_FLT_AMP5_OV] = syncRails[`SSR_RAW_AMP5_OV]; // [R17]
      faultWord[`SSR_FLT_NEG_UV] = syncRails[`SSR_RAW_NEG_UV]; // [R17]
      faultWord[`SSR_FLT_NEG_OV] = syncRails[`SSR_RAW_NEG_OV]; // [R17]
      faultWord[`SSR_FLT_V3P3] = syncRails[`SSR_RAW_V3P3]; // [R18]
      faultWord[`SSR_FLT_V1P8] = syncRails[`SSR_RAW_V1P8]; // [R18]
      faultWord[`SSR_FLT_V1P1] = syncRails[`SSR_RAW_V1P1]; // [R18]
      faultWord[`SSR_FLT_RSVD] = 1'b0; // [R21]
   end

   // Gather the ADC error strobes into flag positions.
   always_comb begin
      adcEvents = '0;
      adcEvents[`SSR_ADC_STOP_BIT] = adcStopBitErr; // [R6]
      adcEvents[`SSR_ADC_TIMELINE] = adcTimelineErr; // [R7]
      adcEvents[`SSR_ADC_COMMAND] = adcCommandErr; // [R8]
      adcEvents[`SSR_ADC_PARITY] = adcParityErr; // [R9]
      adcEvents[`SSR_ADC_CH2_UNDER] = adcCh2Underflow; // [R10]
      adcEvents[`SSR_ADC_CH1_UNDER] = adcCh1Underflow; // [R10]
      adcEvents[`SSR_ADC_CH2_SAT] = adcCh2Saturated; // [R11]
      adcEvents[`SSR_ADC_CH1_SAT] = adcCh1Saturated; // [R11]
   end

   // Reset cause priority when several strike at once: the hardware threats outrank
   // the deliberate requests, so the more serious cause is the one software sees.
   always_comb begin
      causeSeen = 1'b1;
      if (overTempEvent) begin
         causeEvent = `SSR_CAUSE_OVER_TEMP;
      end else if (watchdog1Event) begin
         causeEvent = `SSR_CAUSE_WATCHDOG1;
      end else if (watchdog2Event) begin
         causeEvent = `SSR_CAUSE_WATCHDOG2;
      end else if (swPowerCycleEvent) begin
         causeEvent = `SSR_CAUSE_SW_CYCLE;
      end else if (projOnLowEvent) begin
         causeEvent = `SSR_CAUSE_PROJECTOR_ON_INPUT_LOW;
      end else begin
         causeEvent = `SSR_CAUSE_POWER_ON;
         causeSeen = 1'b0;
      end
   end

   // Entry into the off state is the moment the cause of this reset cycle is final.
   assign offEntry = (topStateIn == ssr_pkg::SSR_ST_OFF) && (st.topState != ssr_pkg::SSR_ST_OFF);

   // Live view of the general status word; reserved bits are forced to zero.
   always_comb begin
      genStatus = `SSR_REG_RESET;
      genStatus[`SSR_GS_RATIO_MSB:`SSR_GS_RATIO_LSB] = st.ratio; // [R1]
      genStatus[`SSR_GS_RSVD_MSB:`SSR_GS_RSVD_LSB] = `SSR_RSVD4; // [R21]
      genStatus[`SSR_GS_CAUSE_MSB:`SSR_GS_CAUSE_LSB] = st.lastReset; // [R2]
      genStatus[`SSR_GS_STATE_MSB:`SSR_GS_STATE_LSB] = st.topState; // [R3]
   end

   // Next-state logic; nothing moves while the clock enable is low.
   always_comb begin
      next_st = st;
      // The read pulse drops only on an enabled edge, so a frozen bank keeps it as well.
      if (clkEn) begin
         next_st.rdValid = 1'b0;
         next_st.ratio = clockRatioCount; // [R1]
         next_st.topState = topStateIn; // [R3]
         next_st.railFault = faultWord; // [R12] [R22]
         // A fresh event in the commit cycle becomes the next pending cause, so it is kept.
         if (offEntry) begin
            next_st.lastReset = st.pendCause; // [R2]
            next_st.pendCause = causeEvent;
         end else if (causeSeen) begin
            next_st.pendCause = causeEvent;
         end
         // Flags are sticky: hardware events and ones written by software only ever set.
         next_st.adcFlags = st.adcFlags | adcEvents; // [R6] [R7] [R8] [R9] [R10] [R11]
         if (regWrEn && ssr_hit(regAddr, `SSR_ADDR_ADC_FLAGS)) begin
            next_st.adcFlags = next_st.adcFlags | regWrData[`SSR_ADC_MSB:0]; // [R4]
         end
         // Writes to the read-only registers and to unmapped offsets fall through here.
         if (regRdEn) begin
            next_st.rdValid = 1'b1;
            if (ssr_hit(regAddr, `SSR_ADDR_GEN_STATUS)) begin
               next_st.rdData = genStatus;
            end else if (ssr_hit(regAddr, `SSR_ADDR_ADC_FLAGS)) begin
               next_st.rdData = {`SSR_ADC_UPPER_ZERO, st.adcFlags}; // [R21]
            end else if (ssr_hit(regAddr, `SSR_ADDR_RAIL_FAULT)) begin
               next_st.rdData = st.railFault; // [R12]
            end else begin
               next_st.rdData = `SSR_REG_RESET;
            end
         end
      end
   end

   // State register; everything clears to zero on reset.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from state flops or from ORs and range compares over them.
   assign regRdData = st.rdData;
   assign regRdValid = st.rdValid;
   assign pgFaultSummary = |st.railFault; // [R19]
   assign adcErrorSummary = |st.adcFlags; // [R5] [R20]
   assign extClockPresent = (st.ratio >= (`SSR_RATIO_MID - `SSR_RATIO_TOL))
      && (st.ratio <= (`SSR_RATIO_MID + `SSR_RATIO_TOL)); // [R1]

   // Checks kept beside the logic they guard.
   sequence s_stopStrobe;
      clkEn && adcStopBitErr;
   endsequence

   sequence s_mainLow;
      (clkEn && mainInputRailUv) [*3];
   endsequence

   property p_stopFlag;
      @(posedge core_clk) disable iff (!reset_n)
      s_stopStrobe |=> st.adcFlags[`SSR_ADC_STOP_BIT] && adcErrorSummary;
   endproperty
   a_stopFlag: assert property (p_stopFlag) else $error("stop-bit flag not set"); // [R6]

   property p_timelineFlag;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn && adcTimelineErr |=> st.adcFlags[`SSR_ADC_TIMELINE];
   endproperty
   a_timelineFlag: assert property (p_timelineFlag) else $error("timeline flag not set"); // [R7]

   property p_cmdParity;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn && (adcCommandErr || adcParityErr) |=>
         (st.adcFlags[`SSR_ADC_COMMAND] == $past(adcCommandErr) || st.adcFlags[`SSR_ADC_COMMAND])
         && (st.adcFlags[`SSR_ADC_PARITY] || !$past(adcParityErr));
   endproperty
   a_cmdParity: assert property (p_cmdParity) else $error("command or parity flag lost"); // [R8] [R9]

   property p_channelFlags;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn |=> ((st.adcFlags[`SSR_ADC_CH2_UNDER:`SSR_ADC_CH1_SAT]
         & $past(adcEvents[`SSR_ADC_CH2_UNDER:`SSR_ADC_CH1_SAT]))
         == $past(adcEvents[`SSR_ADC_CH2_UNDER:`SSR_ADC_CH1_SAT]));
   endproperty
   a_channelFlags: assert property (p_channelFlags) else $error("channel flag lost"); // [R10] [R11]

   property p_writeOneSets;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn && regWrEn && regAddr == `SSR_ADDR_ADC_FLAGS |=>
         ((st.adcFlags & $past(regWrData[`SSR_ADC_MSB:0])) == $past(regWrData[`SSR_ADC_MSB:0]));
   endproperty
   a_writeOneSets: assert property (p_writeOneSets) else $error("write of one did not set flag"); // [R4]

   property p_flagsSticky;
      @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> ((st.adcFlags & $past(st.adcFlags)) == $past(st.adcFlags));
   endproperty
   a_flagsSticky: assert property (p_flagsSticky) else $error("ADC flag dropped"); // [R4]

   property p_adcSummary;
      @(posedge core_clk) disable iff (!reset_n)
      adcErrorSummary == (st.adcFlags != `SSR_ADC_UPPER_ZERO);
   endproperty
   a_adcSummary: assert property (p_adcSummary) else $error("ADC summary mismatch"); // [R5]

   property p_pgSummary;
      @(posedge core_clk) disable iff (!reset_n)
      pgFaultSummary == (st.railFault != `SSR_REG_RESET) && !st.railFault[`SSR_FLT_RSVD];
   endproperty
   a_pgSummary: assert property (p_pgSummary) else $error("power-good summary mismatch"); // [R19] [R21]

   property p_mainRail;
      @(posedge core_clk) disable iff (!reset_n)
      s_mainLow |=> st.railFault[`SSR_FLT_PG1] && pgFaultSummary;
   endproperty
   a_mainRail: assert property (p_mainRail) else $error("main rail fault not reported"); // [R14] [R22]

   property p_causeCommit;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn && offEntry |=> st.lastReset == $past(st.pendCause);
   endproperty
   a_causeCommit: assert property (p_causeCommit) else $error("reset cause not latched"); // [R2]

   property p_genRead;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn && regRdEn && regAddr == `SSR_ADDR_GEN_STATUS |=> regRdValid
         && regRdData[`SSR_GS_RSVD_MSB:`SSR_GS_RSVD_LSB] == `SSR_RSVD4
         && regRdData[`SSR_GS_STATE_MSB:`SSR_GS_STATE_LSB] == $past(st.topState);
   endproperty
   a_genRead: assert property (p_genRead) else $error("general status readback wrong"); // [R3] [R21]

   // Read requests aimed at the two flag registers.
   sequence s_adcRead;
      clkEn && regRdEn && regAddr == `SSR_ADDR_ADC_FLAGS;
   endsequence

   sequence s_faultRead;
      clkEn && regRdEn && regAddr == `SSR_ADDR_RAIL_FAULT;
   endsequence

   property p_ratioTrack;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn |=> st.ratio == $past(clockRatioCount);
   endproperty
   a_ratioTrack: assert property (p_ratioTrack) else $error("ratio count not tracked"); // [R1]

   property p_stateTrack;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn |=> st.topState == $past(topStateIn);
   endproperty
   a_stateTrack: assert property (p_stateTrack) else $error("top state not tracked"); // [R3]

   property p_causeHold;
      @(posedge core_clk) disable iff (!reset_n)
      clkEn && !offEntry |=> $stable(st.lastReset);
   endproperty
   a_causeHold: assert property (p_causeHold) else $error("reset cause moved outside off entry"); // [R2]

   property p_adcRead;
      @(posedge core_clk) disable iff (!reset_n)
      s_adcRead |=> regRdValid && regRdData == {`SSR_ADC_UPPER_ZERO, $past(st.adcFlags)};
   endproperty
   a_adcRead: assert property (p_adcRead) else $error("ADC flag readback wrong"); // [R4] [R21]

   property p_faultRead;
      @(posedge core_clk) disable iff (!reset_n)
      s_faultRead |=> regRdValid && regRdData == $past(st.railFault) && !regRdData[`SSR_FLT_RSVD];
   endproperty
   a_faultRead: assert property (p_faultRead) else $error("rail fault readback wrong"); // [R12] [R21]

   property p_freeze;
      @(posedge core_clk) disable iff (!reset_n)
      !clkEn |=> $stable(st.adcFlags) && $stable(st.lastReset) && $stable(st.railFault);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low"); // [R22]

endmodule : ssr_bank

// *** verification/system_status_register_bank_tb_top.sv ***
`timescale 1ns/1ps
`include "ssr_defines.svh"

module system_status_register_bank_tb_top;
   logic core_clk;
   logic reset_n;
   logic clkEn;
   logic [`SSR_ADDR_W-1:0] regAddr;
   logic regWrEn;
   logic [`SSR_DATA_W-1:0] regWrData;
   logic regRdEn;
   logic [`SSR_DATA_W-1:0] regRdData;
   logic regRdValid;
   logic [`SSR_RATIO_W-1:0] clockRatioCount;
   logic [`SSR_STATE_W-1:0] topStateIn;
   logic [4:0] causeEv;
   logic [7:0] adcIn;
   logic [15:0] railIn;
   logic pgFaultSummary;
   logic adcErrorSummary;
   logic extClockPresent;
   logic [15:0] rd;
   int failures;
   int checkCount;
   // Each row is a raw comparator word beside the fault word it should produce.
   logic [31:0] rows [16] = '{
      {16'h0001, 16'h0401}, {16'h0002, 16'h0402}, {16'h0004, 16'h0404}, {16'h0008, 16'h0008},
      {16'h0010, 16'h0010}, {16'h0020, 16'h0020}, {16'h0040, 16'h0040}, {16'h0080, 16'h0080},
      {16'h0100, 16'h0100}, {16'h0200, 16'h0200}, {16'h0400, 16'h0400}, {16'h0800, 16'h1000},
      {16'h1000, 16'h1000}, {16'h2000, 16'h2000}, {16'h4000, 16'h4000}, {16'h8000, 16'h8000}};

   ssr_bank i_ssr_bank (
      .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
      .clockRatioCount(clockRatioCount), .topStateIn(topStateIn),
      .projOnLowEvent(causeEv[0]), .watchdog1Event(causeEv[1]), .watchdog2Event(causeEv[2]),
      .overTempEvent(causeEv[3]), .swPowerCycleEvent(causeEv[4]),
      .adcStopBitErr(adcIn[7]), .adcTimelineErr(adcIn[6]), .adcCommandErr(adcIn[5]), .adcParityErr(adcIn[4]),
      .adcCh2Underflow(adcIn[3]), .adcCh2Saturated(adcIn[2]), .adcCh1Underflow(adcIn[1]),
      .adcCh1Saturated(adcIn[0]),
      .mirrorBiasRailUv(railIn[`SSR_RAW_MIRROR_BIAS]), .mirrorResetRailUv(railIn[`SSR_RAW_MIRROR_RESET]),
      .mirrorOffsetRailUv(railIn[`SSR_RAW_MIRROR_OFFSET]), .mainInputRailUv(railIn[`SSR_RAW_MAIN_INPUT]),
      .analogSupplyRailUv(railIn[`SSR_RAW_ANALOG]), .supply6vUv(railIn[`SSR_RAW_V6]),
      .conv3vUv(railIn[`SSR_RAW_CONV_UV]), .conv3vOv(railIn[`SSR_RAW_CONV_OV]),
      .amp3vUv(railIn[`SSR_RAW_AMP3_UV]), .amp3vOv(railIn[`SSR_RAW_AMP3_OV]),
      .amp5vOv(railIn[`SSR_RAW_AMP5_OV]), .negPdBiasUv(railIn[`SSR_RAW_NEG_UV]),
      .negPdBiasOv(railIn[`SSR_RAW_NEG_OV]), .supply3p3Uv(railIn[`SSR_RAW_V3P3]),
      .supply1p8Uv(railIn[`SSR_RAW_V1P8]), .supply1p1Uv(railIn[`SSR_RAW_V1P1]),
      .pgFaultSummary(pgFaultSummary), .adcErrorSummary(adcErrorSummary), .extClockPresent(extClockPresent));

   // Free-running system clock at 100 MHz.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Comparisons use case inequality so an unknown never passes.
   task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkWord

   task automatic checkBit(input logic got, input logic exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkBit

   task automatic waitClk(input int n);
      repeat (n) @(posedge core_clk);
   endtask : waitClk

   // One-cycle read strobe; the answer is sampled just after the edge that takes it.
   task automatic readReg(input logic [7:0] addr);
      @(posedge core_clk);
      regRdEn <= 1'b1;
      regAddr <= addr;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      #1;
      checkBit(regRdValid, 1'b1);
      rd = regRdData;
   endtask : readReg

   task automatic writeReg(input logic [7:0] addr, input logic [15:0] data);
      @(posedge core_clk);
      regWrEn <= 1'b1;
      regAddr <= addr;
      regWrData <= data;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask : writeReg

   // Sticky flags have no clear path, so a reset is the only way back to a clean bank.
   task automatic doReset();
      @(posedge core_clk);
      reset_n <= 1'b0;
      waitClk(10);
      reset_n <= 1'b1;
   endtask : doReset

   task automatic summarize();
      if (failures == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   // Main sequence: reset readback first, then table of rail cases, then hand-written cases.
   initial begin
      reset_n = 1'b0;
      clkEn = 1'b1;
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 16'h0000;
      regRdEn = 1'b0;
      clockRatioCount = 4'h0;
      topStateIn = 5'h00;
      causeEv = 5'h00;
      adcIn = 8'h00;
      railIn = 16'h0000;
      failures = 0;
      checkCount = 0;
      waitClk(10);
      reset_n <= 1'b1;
      readReg(`SSR_ADDR_GEN_STATUS);
      checkWord(rd, 16'h0000);
      readReg(`SSR_ADDR_ADC_FLAGS);
      checkWord(rd, 16'h0000);
      readReg(`SSR_ADDR_RAIL_FAULT);
      checkWord(rd, 16'h0000);
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk) railIn <= rows[k][31:16];
         waitClk(4);
         readReg(`SSR_ADDR_RAIL_FAULT);
         checkWord(rd, rows[k][15:0]);
         checkBit(pgFaultSummary, 1'b1);
      end
      @(posedge core_clk) railIn <= 16'h0000;
      writeReg(`SSR_ADDR_RAIL_FAULT, 16'hFFFF);
      waitClk(4);
      readReg(`SSR_ADDR_RAIL_FAULT);
      checkWord(rd, 16'h0000);
      checkBit(pgFaultSummary, 1'b0);
      // Every ADC source alone, each from a clean bank.
      for (int i = 0; i < 8; i++) begin
         doReset();
         checkBit(adcErrorSummary, 1'b0);
         @(posedge core_clk) adcIn <= 8'h01 << i;
         @(posedge core_clk) adcIn <= 8'h00;
         waitClk(2);
         readReg(`SSR_ADDR_ADC_FLAGS);
         checkWord(rd, 16'h0001 << i);
         checkBit(adcErrorSummary, 1'b1);
      end
      // Write-one-to-set, zero leaves flags, upper byte stays zero.
      doReset();
      writeReg(`SSR_ADDR_ADC_FLAGS, 16'hFF81);
      readReg(`SSR_ADDR_ADC_FLAGS);
      checkWord(rd, 16'h0081);
      checkBit(adcErrorSummary, 1'b1);
      writeReg(`SSR_ADDR_ADC_FLAGS, 16'h0000);
      writeReg(`SSR_ADDR_ADC_FLAGS, 16'h0042);
      readReg(`SSR_ADDR_ADC_FLAGS);
      checkWord(rd, 16'h00C3);
      // A write while the clock enable is low must be lost.
      @(posedge core_clk) clkEn <= 1'b0;
      writeReg(`SSR_ADDR_ADC_FLAGS, 16'h0010);
      @(posedge core_clk) clkEn <= 1'b1;
      readReg(`SSR_ADDR_ADC_FLAGS);
      checkWord(rd, 16'h00C3);
      writeReg(`SSR_ADDR_GEN_STATUS, 16'hFFFF);
      readReg(`SSR_ADDR_GEN_STATUS);
      checkWord(rd, 16'h0000);
      readReg(8'h7F);
      checkWord(rd, 16'h0000);
      // Every documented top-level state code.
      for (int c = 0; c < 18; c++) begin
         if (c != 11) begin
            @(posedge core_clk) topStateIn <= 5'(c);
            waitClk(2);
            readReg(`SSR_ADDR_GEN_STATUS);
            checkWord(rd, {11'h000, 5'(c)});
         end
      end
      // Ratio monitor: only the mid-scale band counts as clock present.
      for (int r = 0; r < 16; r++) begin
         @(posedge core_clk) clockRatioCount <= 4'(r);
         waitClk(2);
         checkBit(extClockPresent, (r >= 7 && r <= 9));
         readReg(`SSR_ADDR_GEN_STATUS);
         checkWord(rd, {4'(r), 12'h011});
      end
      @(posedge core_clk) clockRatioCount <= 4'h8;
      // Each reset cause, then a pass through off with no event gives power-on.
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk) topStateIn <= ssr_pkg::SSR_ST_STANDBY;
         causeEv <= (i < 5) ? 5'(5'h01 << i) : 5'h00;
         @(posedge core_clk) causeEv <= 5'h00;
         waitClk(2);
         @(posedge core_clk) topStateIn <= ssr_pkg::SSR_ST_OFF;
         waitClk(3);
         readReg(`SSR_ADDR_GEN_STATUS);
         checkWord(rd, {4'h8, 4'h0, (i < 5) ? 3'(i + 1) : 3'h0, 5'h02});
      end
      summarize();
   end

   // Watchdog against a hung run; the tests need well under this span.
   initial begin
      #200000;
      failures++;
      summarize();
   end
endmodule : system_status_register_bank_tb_top
